// ---- tcw_timer.v ----
// Timer top: 8-bit counter, one compare channel, prescaler and AHB-Lite slave.
// Assumes one clock, a single AHB-Lite master, word-wide single transfers.
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`include "tcw_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module tcw_timer (
    input wire clk,
    input wire arst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire cmp_vector_ack,
    input wire ovf_vector_ack,
    input wire port_data,
    output wire compare_output_pin,
    output wire pin_oe,
    output wire compare_match_flag,
    output wire overflow_flag
);
    reg [1:0] compare_output_mode_q;
    reg [1:0] waveform_mode_sel_q;
    reg [2:0] clock_source_sel_q;
    reg [7:0] counter_value_q;
    reg [7:0] cmp_buf_q;
    reg [7:0] compare_value_q;
    reg cmp_flag_q;
    reg ovf_flag_q;
    reg pin_dir_q;
    reg oc_q;
    reg down_q;
    reg block_q;
    reg [9:0] presc_q;
    reg [9:0] presc_prev_q;
    reg wr_q;
    reg [5:0] addr_q;
    reg [31:0] rdata_q;
    wire ap = hsel & hready & htrans[1];
    wire wr = wr_q;
    wire wr_ca = wr & (addr_q == `TCW_OFS_CTRL_A >> 2);
    wire wr_cb = wr & (addr_q == `TCW_OFS_CTRL_B >> 2);
    wire wr_cnt = wr & (addr_q == `TCW_OFS_COUNT >> 2);
    wire wr_cmp = wr & (addr_q == `TCW_OFS_CMP >> 2);
    wire wr_flg = wr & (addr_q == `TCW_OFS_FLAGS >> 2);
    wire wr_psr = wr & (addr_q == `TCW_OFS_PRESC >> 2) & hwdata[`TCW_PSR_BIT];
    wire wr_port = wr & (addr_q == `TCW_OFS_PORT >> 2);
    wire pwm = waveform_mode_sel_q[0];
    wire [7:0] top = (waveform_mode_sel_q == `TCW_MODE_CTC) ? compare_value_q : `TCW_MAX;
    // Tap edges: a bit falling is one full period of that divide
    wire [9:0] fall = presc_prev_q & ~presc_q;
    reg tick;
    always @* begin
        case (clock_source_sel_q)
            3'h1: tick = 1'b1;
            3'h2: tick = fall[2];
            3'h3: tick = fall[4];
            3'h4: tick = fall[5];
            3'h5: tick = fall[6];
            3'h6: tick = fall[7];
            3'h7: tick = fall[9];
            default: tick = 1'b0;
        endcase
    end
    wire match = tick & ~block_q & (counter_value_q == compare_value_q);
    wire force_cmp = wr_cb & hwdata[`TCW_FORCE_BIT] & ~pwm;
    wire at_top = counter_value_q == top;
    wire at_bottom = counter_value_q == `TCW_BOTTOM;
    wire top_case = pwm & compare_output_mode_q[1] & (compare_value_q == `TCW_MAX);
    reg [7:0] cnt_d;
    reg down_d;
    reg ovf_ev;
    always @* begin
        cnt_d = counter_value_q;
        down_d = down_q;
        ovf_ev = 1'b0;
        if (tick) begin
            if (waveform_mode_sel_q == `TCW_MODE_PCPWM) begin
                if (!down_q && at_top) begin
                    down_d = 1'b1;
                    cnt_d = counter_value_q - 8'h01;
                end else if (down_q && at_bottom) begin
                    down_d = 1'b0;
                    cnt_d = counter_value_q + 8'h01;
                end else begin
                    cnt_d = down_q ? counter_value_q - 8'h01 : counter_value_q + 8'h01;
                end
                ovf_ev = down_q & at_bottom;
            end else begin
                down_d = 1'b0;
                cnt_d = ((waveform_mode_sel_q == `TCW_MODE_CTC) && at_top) ? `TCW_BOTTOM
                        : counter_value_q + 8'h01;
                ovf_ev = counter_value_q == `TCW_MAX;
            end
        end
    end
    // Buffered compare reloads at TOP; its own TOP-reach still compares against the old value
    wire pwm_reload = tick & pwm & (waveform_mode_sel_q == `TCW_MODE_PCPWM ? (!down_q && at_top) : at_top);
    reg oc_d;
    always @* begin
        oc_d = oc_q;
        case (waveform_mode_sel_q)
            `TCW_MODE_NORMAL, `TCW_MODE_CTC: begin
                if (match | force_cmp) begin
                    case (compare_output_mode_q)
                        2'h1: oc_d = ~oc_q;
                        2'h2: oc_d = 1'b0;
                        2'h3: oc_d = 1'b1;
                        default: oc_d = oc_q;
                    endcase
                end
            end
            `TCW_MODE_FPWM: begin
                if (compare_output_mode_q[1]) begin
                    if (top_case) begin
                        if (tick && at_top) oc_d = ~compare_output_mode_q[0];
                    end else if (match) begin
                        // Code 10 clears on match, code 11 sets
                        oc_d = compare_output_mode_q[0];
                    end else if (tick && counter_value_q == `TCW_MAX) begin
                        // Wrap to bottom takes the opposite level
                        oc_d = ~compare_output_mode_q[0];
                    end
                end
            end
            default: begin
                if (compare_output_mode_q[1]) begin
                    if (top_case) begin
                        if (tick && at_top && !down_q) oc_d = ~compare_output_mode_q[0];
                    end else if (match) begin
                        oc_d = down_q ? ~compare_output_mode_q[0] : compare_output_mode_q[0];
                    end
                end
            end
        endcase
    end
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            compare_output_mode_q <= 2'h0;
            waveform_mode_sel_q <= 2'h0;
            clock_source_sel_q <= 3'h0;
            counter_value_q <= `TCW_RST_BYTE;
            cmp_buf_q <= `TCW_RST_BYTE;
            compare_value_q <= `TCW_RST_BYTE;
            cmp_flag_q <= 1'b0;
            ovf_flag_q <= 1'b0;
            pin_dir_q <= 1'b0;
            oc_q <= 1'b0;
            down_q <= 1'b0;
            block_q <= 1'b0;
            presc_q <= 10'h000;
            presc_prev_q <= 10'h000;
            wr_q <= 1'b0;
            addr_q <= 6'h00;
            rdata_q <= 32'h00000000;
        end else begin
            wr_q <= ap & hwrite;
            if (ap) addr_q <= haddr[7:2];
            // Prescaler free-runs; reset zeroes both copies so no false edge
            if (wr_psr) begin
                presc_q <= 10'h000;
                presc_prev_q <= 10'h000;
            end else begin
                presc_q <= presc_q + 10'h001;
                presc_prev_q <= presc_q;
            end
            if (wr_ca) begin
                compare_output_mode_q <= hwdata[`TCW_COM_HI:`TCW_COM_LO];
                waveform_mode_sel_q[0] <= hwdata[`TCW_WGM0_BIT];
                waveform_mode_sel_q[1] <= hwdata[`TCW_WGM1_BIT];
            end
            if (wr_cb) clock_source_sel_q <= hwdata[`TCW_CS_HI:`TCW_CS_LO];
            if (wr_cnt) begin
                counter_value_q <= hwdata[7:0];
                block_q <= 1'b1;
            end else begin
                counter_value_q <= cnt_d;
                down_q <= down_d;
                if (tick) block_q <= 1'b0;
            end
            if (wr_cmp) begin
                cmp_buf_q <= hwdata[7:0];
                if (!pwm) compare_value_q <= hwdata[7:0];
            end else if (!pwm) begin
                compare_value_q <= cmp_buf_q;
            end else if (pwm_reload) begin
                compare_value_q <= cmp_buf_q;
            end
            // Set wins over clear; forced match never sets the flag
            if (match) cmp_flag_q <= 1'b1;
            else if (cmp_vector_ack || (wr_flg && hwdata[`TCW_FLAG_CMP_BIT])) cmp_flag_q <= 1'b0;
            if (ovf_ev) ovf_flag_q <= 1'b1;
            else if (ovf_vector_ack || (wr_flg && hwdata[`TCW_FLAG_OVF_BIT])) ovf_flag_q <= 1'b0;
            if (wr_port) pin_dir_q <= hwdata[0];
            oc_q <= oc_d;
            if (ap && !hwrite) begin
                case (haddr[7:2])
                    // Bit 6 shows both output mode bit 0 and waveform bit 0, written together;
                    // waveform bit 1 sits in the reserved span and so cannot be read back
                    `TCW_OFS_CTRL_A >> 2: rdata_q <= {24'h000000, compare_output_mode_q, 6'h00};
                    `TCW_OFS_CTRL_B >> 2: rdata_q <= {29'h00000000, clock_source_sel_q};
                    `TCW_OFS_COUNT >> 2: rdata_q <= {24'h000000, counter_value_q};
                    `TCW_OFS_CMP >> 2: rdata_q <= {24'h000000, cmp_buf_q};
                    `TCW_OFS_FLAGS >> 2: rdata_q <= {30'h00000000, cmp_flag_q, ovf_flag_q};
                    `TCW_OFS_PORT >> 2: rdata_q <= {31'h00000000, pin_dir_q};
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign compare_output_pin = (compare_output_mode_q != 2'h0) ? oc_q : port_data;
    // Fast/phase PWM with code 01 still drives the held oc_q, not port_data
    assign pin_oe = pin_dir_q;
    assign compare_match_flag = cmp_flag_q;
    assign overflow_flag = ovf_flag_q;
endmodule
`default_nettype wire

// ---- tcw_defs.vh ----
// Register map, field positions and reset values of the 8-bit compare timer.
// Included by the timer top; no logic here.
`ifndef TCW_DEFS_VH
`define TCW_DEFS_VH
`define TCW_OFS_CTRL_A 8'h00
`define TCW_OFS_CTRL_B 8'h04
`define TCW_OFS_COUNT 8'h08
`define TCW_OFS_CMP 8'h0C
`define TCW_OFS_FLAGS 8'h10
`define TCW_OFS_PRESC 8'h14
`define TCW_OFS_PORT 8'h18
`define TCW_COM_HI 7
`define TCW_COM_LO 6
`define TCW_WGM1_BIT 3
`define TCW_WGM0_BIT 6
`define TCW_FORCE_BIT 7
`define TCW_CS_HI 2
`define TCW_CS_LO 0
`define TCW_FLAG_CMP_BIT 1
`define TCW_FLAG_OVF_BIT 0
`define TCW_PSR_BIT 1
`define TCW_MODE_NORMAL 2'h0
`define TCW_MODE_PCPWM 2'h1
`define TCW_MODE_CTC 2'h2
`define TCW_MODE_FPWM 2'h3
`define TCW_MAX 8'hFF
`define TCW_BOTTOM 8'h00
`define TCW_RST_BYTE 8'h00
`endif

// ---- tcw_timer_assertions.sv ----
// Port checker for the compare timer.
// Assumes one clock and a zero-wait AHB-Lite master.
`timescale 1ns/1ns
`default_nettype none
module tcw_timer_assertions (
    input wire clk,
    input wire arst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire cmp_vector_ack,
    input wire ovf_vector_ack,
    input wire port_data,
    input wire compare_output_pin,
    input wire pin_oe,
    input wire compare_match_flag,
    input wire overflow_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Bus tied ready, so hready is left out
    wire av = hsel & htrans[1];
    wire rd = av & !hwrite;
    wire wp = av & hwrite & (haddr[7:0] == 8'h18);
    wire wf = av & hwrite & (haddr[7:0] == 8'h10);
    logic wa_q;
    logic [1:0] com_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wa_q <= 1'b0;
            com_q <= 2'h0;
        end else begin
            wa_q <= av & hwrite & (haddr[7:0] == 8'h00);
            if (wa_q) begin
                com_q <= hwdata[7:6];
            end
        end
    end
    chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
    chk_rdata_upper: assert property (hrdata[31:8] == 24'h000000) else $error("hrdata upper set");
    chk_rdata_hold: assert property (!$stable(hrdata) |-> $past(rd)) else $error("hrdata moved");
    chk_oe_source: assert property (!$stable(pin_oe) |-> $past(wp) || $past(wp, 2) || $past(wp, 3))
        else $error("pin_oe moved without write");
    chk_pin_port: assert property (com_q == 2'h0 && $past(com_q) == 2'h0 && $stable(port_data)
        |-> compare_output_pin == port_data) else $error("pin not port value");
    chk_cmp_clear: assert property ($fell(compare_match_flag)
        |-> $past(cmp_vector_ack) || $past(wf, 2) || $past(wf, 3)) else $error("compare flag lost");
    chk_ovf_clear: assert property ($fell(overflow_flag)
        |-> $past(ovf_vector_ack) || $past(wf, 2) || $past(wf, 3)) else $error("overflow flag lost");
    cov_cmp: cover property ($rose(compare_match_flag));
    cov_ovf: cover property ($rose(overflow_flag));
    cov_oe: cover property ($rose(pin_oe));
endmodule
`default_nettype wire

// ---- tcw_pin_load.sv ----
// Pad load on the compare output pin.
// Assumes a pull-up on the board side of the pad.
`timescale 1ns/1ns
`default_nettype none
module tcw_pin_load (
    input wire logic compare_output_pin,
    input wire logic pin_oe,
    output logic pad
);
    // Released pad floats to the pull-up, not the last value
    assign pad = pin_oe ? compare_output_pin : 1'b1;
endmodule
`default_nettype wire

// ---- tcw_testbench.sv ----
// Bench of the compare timer: AHB-Lite master, scenarios, verdict.
// Assumes the timer, its checker and the pad load are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic cmp_vector_ack = 1'b0;
    logic ovf_vector_ack = 1'b0;
    logic port_data = 1'b0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, compare_output_pin, pin_oe, compare_match_flag, overflow_flag, pad;
    int checked = 0;
    int mismatches = 0;
    int n;
    logic [7:0] v, c;
    tcw_timer u_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(1'b1), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cmp_vector_ack(cmp_vector_ack), .ovf_vector_ack(ovf_vector_ack), .port_data(port_data),
        .compare_output_pin(compare_output_pin), .pin_oe(pin_oe), .compare_match_flag(compare_match_flag),
        .overflow_flag(overflow_flag));
    tcw_pin_load u_load (.compare_output_pin(compare_output_pin), .pin_oe(pin_oe), .pad(pad));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Entered just after a rising edge; returns at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic t_regs();
        bus(1'b0, 8'h08, 8'h00, v);
        `CK("count reset", 8'h00, v)
        wr(8'h04, 8'hF8);
        bus(1'b0, 8'h04, 8'h00, v);
        `CK("ctrl b", 8'h00, v)
        wr(8'h00, 8'h3C);
        bus(1'b0, 8'h00, 8'h00, v);
        `CK("ctrl a reserved", 8'h00, v & 8'h3C)
        port_data <= 1'b1;
        repeat (2) @(posedge clk);
        `CK("port path", 1'b1, compare_output_pin)
        port_data <= 1'b0;
        wr(8'h08, 8'hA5);
        bus(1'b0, 8'h08, 8'h00, v);
        `CK("count rw", 8'hA5, v)
        wr(8'h0C, 8'h5A);
        bus(1'b0, 8'h0C, 8'h00, v);
        `CK("compare now", 8'h5A, v)
        bus(1'b0, 8'h1C, 8'h00, v);
        `CK("unmapped", 8'h00, v)
        $display("test regs done");
    endtask
    task automatic t_ctc();
        wr(8'h18, 8'h01);
        @(posedge clk);
        `CK("oe on", 1'b1, pin_oe)
        wr(8'h10, 8'h03);
        wr(8'h0C, 8'h05);
        wr(8'h08, 8'h00);
        wr(8'h00, 8'h88);
        wr(8'h04, 8'h01);
        for (n = 0; n < 60 && compare_match_flag !== 1'b1; n++) @(posedge clk);
        `CK("match flag", 1'b1, compare_match_flag)
        repeat (40) @(posedge clk);
        wr(8'h04, 8'h00);
        bus(1'b0, 8'h08, 8'h00, v);
        `CK("count in top", 1'b1, v <= 8'h05)
        `CK("no overflow", 1'b0, overflow_flag)
        `CK("pin clear", 1'b0, pad)
        wr(8'h10, 8'h02);
        @(posedge clk);
        `CK("flag w1c", 1'b0, compare_match_flag)
        $display("test ctc done");
    endtask
    task automatic t_force();
        wr(8'h0C, 8'h10);
        wr(8'h08, 8'h00);
        wr(8'h00, 8'hC8);
        wr(8'h04, 8'h01);
        repeat (40) @(posedge clk);
        wr(8'h04, 8'h00);
        `CK("inverting set", 1'b1, pad)
        // Strobe written in PWM on purpose; must change nothing
        wr(8'h04, 8'h80);
        repeat (2) @(posedge clk);
        `CK("pwm force", 1'b1, pad)
        wr(8'h00, 8'h88);
        wr(8'h10, 8'h03);
        bus(1'b0, 8'h08, 8'h00, c);
        wr(8'h04, 8'h80);
        repeat (2) @(posedge clk);
        `CK("forced clear", 1'b0, pad)
        `CK("forced no flag", 1'b0, compare_match_flag)
        bus(1'b0, 8'h08, 8'h00, v);
        `CK("forced keeps count", c, v)
        $display("test force done");
    endtask
    task automatic t_ovf();
        wr(8'h00, 8'h00);
        wr(8'h08, 8'hF0);
        wr(8'h04, 8'h01);
        for (n = 0; n < 60 && overflow_flag !== 1'b1; n++) @(posedge clk);
        `CK("overflow", 1'b1, overflow_flag)
        wr(8'h04, 8'h00);
        ovf_vector_ack <= 1'b1;
        @(posedge clk);
        ovf_vector_ack <= 1'b0;
        @(posedge clk);
        `CK("ovf ack", 1'b0, overflow_flag)
        wr(8'h08, 8'h00);
        wr(8'h14, 8'h02);
        wr(8'h04, 8'h02);
        repeat (80) @(posedge clk);
        wr(8'h04, 8'h00);
        bus(1'b0, 8'h08, 8'h00, v);
        `CK("divide by 8", 1'b1, v >= 8'h09 && v <= 8'h0C)
        $display("test ovf done");
    endtask
    // Phase-correct, code 11: set on the way up, clear on the way down
    task automatic t_pc();
        wr(8'h00, 8'h00);
        wr(8'h0C, 8'h10);
        wr(8'h08, 8'h00);
        wr(8'h10, 8'h03);
        wr(8'h00, 8'hC0);
        wr(8'h04, 8'h01);
        repeat (40) @(posedge clk);
        wr(8'h04, 8'h00);
        `CK("pc up set", 1'b1, pad)
        wr(8'h04, 8'h01);
        for (n = 0; n < 600 && overflow_flag !== 1'b1; n++) @(posedge clk);
        wr(8'h04, 8'h00);
        `CK("pc overflow", 1'b1, overflow_flag)
        `CK("pc down clear", 1'b0, pad)
        bus(1'b0, 8'h08, 8'h00, v);
        `CK("pc turn at bottom", 1'b1, v <= 8'h05)
        $display("test pc done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_ctc();
        t_force();
        t_ovf();
        t_pc();
        conclude();
    end
    // Whole run is near 800 cycles; this is far beyond it
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end
endmodule
bind tcw_timer tcw_timer_assertions u_chk (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cmp_vector_ack(cmp_vector_ack), .ovf_vector_ack(ovf_vector_ack), .port_data(port_data),
    .compare_output_pin(compare_output_pin), .pin_oe(pin_oe), .compare_match_flag(compare_match_flag),
    .overflow_flag(overflow_flag));
`default_nettype wire
